// File: src/tbd_defines.svh
`ifndef TBD_DEFINES_SVH
`define TBD_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TBD_IDX_BUS_CONTROL      6'h18
`define TBD_IDX_BUS_STATUS_ONE   6'h19
`define TBD_IDX_BUS_STATUS_TWO   6'h1a
`define TBD_IDX_BUS_CLOCK_CTRL   6'h1b
`define TBD_IDX_OWN_STATION_LOW  6'h1c
`define TBD_IDX_OWN_STATION_HIGH 6'h1d
`define TBD_IDX_BYTE_BUFFER      6'h1e

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TBD_CR_ON       5
`define TBD_CR_ENGC     4
`define TBD_CR_ACK      2
`define TBD_OSH_BAND_HI 7
`define TBD_OSH_BAND_LO 6
`define TBD_OSH_A9      2
`define TBD_OSH_A8      1
`define TBD_OSH_MASK    8'hc6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TBD_RST_CONTROL   8'h00
`define TBD_RST_CLOCK     8'h00
`define TBD_RST_OWN_LOW   8'h00
`define TBD_RST_OWN_HIGH  8'h40
`define TBD_RST_BUFFER    8'h00

// ----------------------------------------------------------------
// Bus address constants and hold delays per speed band
// ----------------------------------------------------------------
`define TBD_ADDR_IGNORED  7'h01
`define TBD_HDR10_MARK    5'h1e
`define TBD_HOLD_NS_B0    40
`define TBD_HOLD_NS_B1    60
`define TBD_HOLD_NS_B2    80
`define TBD_CLK_NS        10
`define TBD_HOLD_CYC(ns)  (((ns) + `TBD_CLK_NS - 1) / `TBD_CLK_NS)

`endif

// File: src/tbd_pkg.sv
package tbd_pkg;

    // Serial engine states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_ADDR  = 4'b0001,
        ST_AACK  = 4'b0010,
        ST_ADDR2 = 4'b0011,
        ST_A2ACK = 4'b0100,
        ST_TXD   = 4'b0101,
        ST_TACK  = 4'b0110,
        ST_RXD   = 4'b0111,
        ST_RACK  = 4'b1000,
        ST_HOLD  = 4'b1001
    } tbd_state_t;

endpackage : tbd_pkg

// File: src/tbd_twi_slave.sv
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tbd_defines.svh"

module tbd_twi_slave
    import tbd_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // Avalon-MM slave
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Two-wire bus pins, open drain
    input  wire logic        SCL_IN,
    output logic             SCL_OUT,
    output logic             SCL_OE_N,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_N
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic       ack_q;
    logic       req;
    logic       acc_rd;
    logic       acc_wr;
    logic [5:0] idx;
    logic       aligned;
    logic [7:0] rd_mux;
    logic [7:0] wbyte;

    // One wait state: request taken on the second edge
    assign req             = AVS_READ | AVS_WRITE;
    assign AVS_WAITREQUEST = req & ~ack_q;
    assign acc_rd          = AVS_READ & ack_q;
    assign acc_wr          = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
    assign idx             = AVS_ADDRESS[7:2];
    assign aligned         = (AVS_ADDRESS[1:0] == 2'b00);
    assign wbyte           = AVS_WRITEDATA[7:0];

    // Register state
    logic [7:0] ctl;
    logic [7:0] clk_ctl;
    logic [7:0] own_low;
    logic [7:0] own_high;
    logic [7:0] byte_buffer;
    logic       tx_empty;
    logic       rx_full;
    logic       btf;
    logic       adsl;
    logic       tra;
    logic       busy;
    logic       add10;
    logic       af;
    logic       stopf;
    logic       berr;
    logic       gcal;

    logic interface_on;
    logic ctl_ack;
    logic engc;
    logic [1:0] core_speed_band;
    assign interface_on    = ctl[`TBD_CR_ON];
    assign ctl_ack         = ctl[`TBD_CR_ACK];
    assign engc            = ctl[`TBD_CR_ENGC];
    assign core_speed_band = own_high[`TBD_OSH_BAND_HI:`TBD_OSH_BAND_LO];

    // Decoded accesses
    logic hit_cr, hit_sr1, hit_sr2, hit_ccr, hit_osl, hit_osh, hit_dr;
    assign hit_cr  = aligned && idx == `TBD_IDX_BUS_CONTROL;
    assign hit_sr1 = aligned && idx == `TBD_IDX_BUS_STATUS_ONE;
    assign hit_sr2 = aligned && idx == `TBD_IDX_BUS_STATUS_TWO;
    assign hit_ccr = aligned && idx == `TBD_IDX_BUS_CLOCK_CTRL;
    assign hit_osl = aligned && idx == `TBD_IDX_OWN_STATION_LOW;
    assign hit_osh = aligned && idx == `TBD_IDX_OWN_STATION_HIGH;
    assign hit_dr  = aligned && idx == `TBD_IDX_BYTE_BUFFER;

    logic [7:0] sr1;
    logic [7:0] sr2;
    assign sr1 = {btf | adsl | af | stopf | berr, add10, tra, busy, btf, adsl, 2'b00};
    assign sr2 = {3'b000, af, stopf, 1'b0, berr, gcal};

    // Read mux; unmapped addresses read zero
    assign rd_mux = hit_cr  ? ctl :
                    hit_sr1 ? sr1 :
                    hit_sr2 ? sr2 :
                    hit_ccr ? clk_ctl :
                    hit_osl ? own_low :
                    hit_osh ? (own_high & `TBD_OSH_MASK) :
                    hit_dr  ? byte_buffer : 8'h00;

    // Answer flop and read data
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_q        <= 1'b0;
            AVS_READDATA <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (AVS_READ && !ack_q) begin
                AVS_READDATA <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Software-owned control registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctl      <= `TBD_RST_CONTROL;
            clk_ctl  <= `TBD_RST_CLOCK;
            own_low  <= `TBD_RST_OWN_LOW;
            own_high <= `TBD_RST_OWN_HIGH;
        end else if (acc_wr) begin
            if (hit_cr) begin
                ctl <= wbyte;
            end
            if (hit_ccr) begin
                clk_ctl <= wbyte;
            end
            // Switching off never touches own address bits
            if (hit_osl) begin
                own_low <= wbyte;
            end
            if (hit_osh) begin
                own_high[`TBD_OSH_A9:`TBD_OSH_A8] <= wbyte[`TBD_OSH_A9:`TBD_OSH_A8];
                // Band writes while on are dropped so timing never shifts mid-frame
                if (!interface_on) begin
                    own_high[`TBD_OSH_BAND_HI:`TBD_OSH_BAND_LO] <=
                        wbyte[`TBD_OSH_BAND_HI:`TBD_OSH_BAND_LO];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and bus events
    // ------------------------------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], SCL_IN};
            sda_sync <= {sda_sync[0], SDA_IN};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl       = scl_sync[1];
    assign sda       = sda_sync[1];
    assign scl_rise  = scl & ~scl_q;
    assign scl_fall  = ~scl & scl_q;
    assign bus_start = scl & scl_q & sda_q & ~sda;
    assign bus_stop  = scl & scl_q & ~sda_q & sda;

    // ------------------------------------------------------------
    // Address matching
    // ------------------------------------------------------------
    tbd_state_t state;
    logic [7:0] sh;
    logic [7:0] tx_sh;
    logic [2:0] bitn;
    logic       rw;
    logic       hdr_write;
    logic       ten_ok;
    logic       nack;
    logic       lead_fall;

    logic hdr10;
    logic match7;
    logic gc_hit;
    logic match10_low;
    assign hdr10       = sh[7:3] == `TBD_HDR10_MARK &&
                         sh[2:1] == own_high[`TBD_OSH_A9:`TBD_OSH_A8];
    assign match7      = sh[7:3] != `TBD_HDR10_MARK &&
                         sh[7:1] == own_low[7:1] &&
                         sh[7:1] != `TBD_ADDR_IGNORED;
    assign gc_hit      = engc && sh == 8'h00;
    assign match10_low = sh == own_low;

    // ------------------------------------------------------------
    // Hold delay before SDA changes after SCL falls
    // ------------------------------------------------------------
    logic [3:0] hold_cyc;
    logic [3:0] dly;
    logic       sda_want;
    logic       sda_low;
    logic       hold_go;
    logic       setup_hold;
    assign hold_cyc = (core_speed_band == 2'b00) ? 4'(`TBD_HOLD_CYC(`TBD_HOLD_NS_B0)) :
                      (core_speed_band == 2'b01) ? 4'(`TBD_HOLD_CYC(`TBD_HOLD_NS_B1)) :
                                                   4'(`TBD_HOLD_CYC(`TBD_HOLD_NS_B2));

    logic wait_done;
    assign wait_done = state == ST_HOLD && (tra ? !tx_empty : !rx_full);
    assign hold_go   = scl_fall | wait_done;

    // Drive value for the current bit slot; 1 pulls SDA low
    assign sda_want = (state == ST_AACK || state == ST_A2ACK) ? 1'b1 :
                      (state == ST_RACK) ? ctl_ack :
                      (state == ST_TXD) ? ~tx_sh[7] : 1'b0;

    // After a stretch SCL stays low until the new bit has been placed on SDA
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dly        <= 4'h0;
            sda_low    <= 1'b0;
            setup_hold <= 1'b0;
        end else if (!interface_on || bus_stop || bus_start) begin
            dly        <= 4'h0;
            sda_low    <= 1'b0;
            setup_hold <= 1'b0;
        end else if (hold_go) begin
            dly        <= hold_cyc;
            setup_hold <= wait_done;
        end else if (dly != 4'h0) begin
            dly <= dly - 4'h1;
            if (dly == 4'h1) begin
                sda_low    <= sda_want;
                setup_hold <= 1'b0;
            end
        end
    end

    assign SDA_OUT  = 1'b0;
    assign SDA_OE_N = ~sda_low;
    assign SCL_OUT  = 1'b0;
    // Stretch while software owes a buffer access, then until the first bit is set up,
    // so a transmitted zero never moves SDA while SCL is high
    assign SCL_OE_N = ~(state == ST_HOLD || setup_hold);

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    tbd_state_t next_state;
    always_comb begin
        next_state = state;
        if (!interface_on || bus_stop) begin
            next_state = ST_IDLE;
        end else if (bus_start) begin
            next_state = ST_ADDR;
        end else if (wait_done) begin
            next_state = tra ? ST_TXD : ST_RXD;
        end else if (scl_fall) begin
            case (state)
                ST_ADDR: begin
                    if (bitn == 3'd7) begin
                        if ((hdr10 && (!sh[0] || ten_ok)) || match7 || gc_hit) begin
                            next_state = ST_AACK;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end
                end
                ST_AACK:  next_state = hdr_write ? ST_ADDR2 : (rw ? ST_HOLD : ST_RXD);
                ST_ADDR2: next_state = (bitn == 3'd7) ?
                                       (match10_low ? ST_A2ACK : ST_IDLE) : ST_ADDR2;
                ST_A2ACK: next_state = ST_RXD;
                ST_RXD:   next_state = (bitn == 3'd7) ? ST_RACK : ST_RXD;
                ST_RACK:  next_state = ST_HOLD;
                ST_TXD:   next_state = (bitn == 3'd7) ? ST_TACK : ST_TXD;
                ST_TACK:  next_state = nack ? ST_IDLE : ST_HOLD;
                default:  next_state = state;
            endcase
        end
    end

    // Engine registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state     <= ST_IDLE;
            sh        <= 8'h00;
            tx_sh     <= 8'h00;
            bitn      <= 3'd0;
            rw        <= 1'b0;
            hdr_write <= 1'b0;
            ten_ok    <= 1'b0;
            nack      <= 1'b0;
            lead_fall <= 1'b0;
        end else begin
            state <= next_state;
            if (!interface_on || bus_start) begin
                bitn      <= 3'd0;
                hdr_write <= 1'b0;
                // The clock fall that closes a start carries no address bit
                lead_fall <= interface_on;
                if (!interface_on) begin
                    ten_ok <= 1'b0;
                end
            end else if (bus_stop) begin
                ten_ok <= 1'b0;
            end else if (wait_done) begin
                bitn <= 3'd0;
                if (tra) begin
                    tx_sh <= byte_buffer;
                end
            end else if (scl_rise) begin
                sh <= {sh[6:0], sda};
                if (state == ST_TACK) begin
                    nack <= sda;
                end
            end else if (scl_fall && lead_fall) begin
                lead_fall <= 1'b0;
            end else if (scl_fall) begin
                bitn <= bitn + 3'd1;
                if (state == ST_TXD) begin
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
                if (state == ST_ADDR && bitn == 3'd7) begin
                    rw        <= sh[0];
                    hdr_write <= hdr10 && !sh[0];
                end
                if (state == ST_A2ACK) begin
                    ten_ok <= 1'b1;
                    bitn   <= 3'd0;
                end
                if (state == ST_AACK || state == ST_RACK) begin
                    bitn <= 3'd0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Byte buffer and status flags; hardware set wins over clear
    // ------------------------------------------------------------
    logic rx_done;
    logic addr_ok;
    logic rd_dr;
    logic wr_dr;
    logic rd_sr2;
    assign rx_done = scl_fall && state == ST_RXD && bitn == 3'd7;
    assign addr_ok = scl_fall && ((state == ST_AACK && !hdr_write) || state == ST_A2ACK);
    assign rd_dr   = acc_rd && hit_dr;
    assign wr_dr   = acc_wr && hit_dr;
    assign rd_sr2  = acc_rd && hit_sr2;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            byte_buffer <= `TBD_RST_BUFFER;
            tx_empty    <= 1'b1;
            rx_full     <= 1'b0;
            btf         <= 1'b0;
            adsl        <= 1'b0;
            tra         <= 1'b0;
            busy        <= 1'b0;
            add10       <= 1'b0;
            af          <= 1'b0;
            stopf       <= 1'b0;
            berr        <= 1'b0;
            gcal        <= 1'b0;
        end else begin
            // Buffer: received byte overrides a same-cycle software write
            if (rx_done) begin
                byte_buffer <= sh;
            end else if (wr_dr) begin
                byte_buffer <= wbyte;
            end
            tx_empty <= (wait_done && tra) ? 1'b1 : (wr_dr ? 1'b0 : tx_empty);
            rx_full  <= rx_done ? 1'b1 : (rd_dr ? 1'b0 : rx_full);
            btf  <= (rx_done || (scl_fall && state == ST_TACK && !nack)) ? 1'b1 :
                    ((rd_dr || wr_dr) ? 1'b0 : btf);
            adsl <= addr_ok ? 1'b1 : ((acc_rd && hit_sr1) || bus_stop ? 1'b0 : adsl);
            if (addr_ok) begin
                tra   <= rw;
                add10 <= state == ST_A2ACK || hdr10;
            end
            busy <= bus_start ? 1'b1 : (bus_stop ? 1'b0 : busy);
            af    <= (scl_fall && state == ST_TACK && nack) ? 1'b1 : (rd_sr2 ? 1'b0 : af);
            stopf <= (bus_stop && adsl) ? 1'b1 : (rd_sr2 ? 1'b0 : stopf);
            berr  <= ((bus_start || bus_stop) && bitn != 3'd0 && state != ST_IDLE) ? 1'b1 :
                     (rd_sr2 ? 1'b0 : berr);
            gcal  <= (scl_fall && state == ST_ADDR && bitn == 3'd7 && gc_hit) ? 1'b1 :
                     (bus_stop ? 1'b0 : gcal);
            // Switching off clears the event flags but never own addresses
            if (!interface_on) begin
                af       <= 1'b0;
                stopf    <= 1'b0;
                berr     <= 1'b0;
                gcal     <= 1'b0;
                btf      <= 1'b0;
                adsl     <= 1'b0;
                busy     <= 1'b0;
                rx_full  <= 1'b0;
                tx_empty <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_bus_answer: assert property ( // bus
        AVS_WAITREQUEST |=> (!AVS_WAITREQUEST || !req))
        else $error("bus answer not after one wait state");

    chk_rx_capture: assert property (
        rx_done && interface_on |=> byte_buffer == $past(sh))
        else $error("received byte not placed in buffer");

    chk_tx_start: assert property (
        state == ST_HOLD && tra && wr_dr && interface_on && !bus_stop && !bus_start
        |=> ##1 state == ST_TXD && tx_sh == $past(wbyte, 2))
        else $error("buffer write did not start transmission");

    chk_rx_dir: assert property (
        addr_ok && !rw && interface_on |=> !tra)
        else $error("write address did not select receive");

    chk_rx_stall: assert property (
        state == ST_HOLD && !tra && rx_full |-> !SCL_OE_N)
        else $error("clock not held while buffer unread");

    chk_addr_ignore: assert property (
        state == ST_ADDR && scl_fall && bitn == 3'd7 && sh[7:1] == `TBD_ADDR_IGNORED
        && !gc_hit |=> state != ST_AACK)
        else $error("address 01h answered");

    chk_own_keep: assert property (
        !interface_on && !(acc_wr && (hit_osl || hit_osh)) |=>
        $stable(own_low) && $stable(own_high))
        else $error("own address changed while off");

    chk_band_lock: assert property (
        interface_on |=> $stable(core_speed_band))
        else $error("speed band changed while on");

    chk_hold_delay: assert property (
        scl_fall && interface_on && !bus_start && !bus_stop |=> dly == hold_cyc)
        else $error("hold delay not taken from speed band");

    chk_reserved_zero: assert property (
        acc_rd && hit_osh |=> AVS_READDATA[5:3] == 3'b000 && AVS_READDATA[0] == 1'b0)
        else $error("reserved bits read nonzero");

    cov_addressed: cover property (addr_ok);
    cov_tx_byte:   cover property (state == ST_TACK ##[1:200] state == ST_HOLD);
    cov_rx_stall:  cover property (state == ST_HOLD && !tra && !SCL_OE_N);
    cov_ten_bit:   cover property (state == ST_A2ACK);

endmodule : tbd_twi_slave

// File: bench/tbd_far_master.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side master on the pulled-up two-wire bus
// ----------------------------------------------------------------
module tbd_far_master (
    // Clock and wired line levels
    input  wire logic CLK,
    input  wire logic scl,
    input  wire logic sda,
    // Open-drain drives, low pulls the line
    output logic      scl_drv,
    output logic      sda_drv
);
    int lat;
    int tmo = 0;
    // Both lines released at start
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // Release clock; bounded wait while the slave stretches it
    task automatic rise();
        scl_drv <= 1'b1;
        for (int i = 0; i < 4000 && scl !== 1'b1; i++) @(posedge CLK);
        // A stretch that never ends is counted by the bench as a mismatch
        if (scl !== 1'b1) tmo++;
        repeat (20) @(posedge CLK);
    endtask : rise
    // Low half counting cycles until SDA is pulled, then one pulse
    task automatic pulse(output logic b);
        lat = 0;
        for (int i = 0; i < 20; i++) begin
            @(posedge CLK);
            if (sda === 1'b1 && lat == i) lat = i + 1;
        end
        rise();
        b = sda;
        scl_drv <= 1'b0;
        // Data waits past the fall so no false start is seen
        repeat (3) @(posedge CLK);
    endtask : pulse
    // Byte out MSB first; nack is the level in the ninth pulse
    task automatic send(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            sda_drv <= d[i];
            pulse(nack);
        end
        sda_drv <= 1'b1;
        pulse(nack);
    endtask : send
    // Byte in MSB first, then ack or nack
    task automatic recv(input logic nack, output logic [7:0] d);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            pulse(b);
            d[i] = b;
        end
        sda_drv <= nack;
        pulse(b);
    endtask : recv
    // Start and stop: data moves while the clock is high
    task automatic start();
        repeat (20) @(posedge CLK);
        sda_drv <= 1'b0;
        repeat (20) @(posedge CLK);
        scl_drv <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask : start
    task automatic stop();
        sda_drv <= 1'b0;
        repeat (20) @(posedge CLK);
        rise();
        sda_drv <= 1'b1;
    endtask : stop
endmodule : tbd_far_master

// File: bench/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Register-side bench for the two-wire slave
// ----------------------------------------------------------------
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wait_req;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        scl_drv;
    logic        sda_drv;
    logic        scl_out;
    logic        sda_out;
    logic        nk;
    logic [7:0]  q;
    logic [7:0]  q2;
    int          lat0;
    int          miscompares = 0;
    int          total_checks = 0;
    logic [7:0]  tab [10] = '{8'h55,8'h54,8'h54,8'h54,8'h55,8'h56,8'h02,8'h02,8'h03,8'h02};
    // Wired-and lines with pull-ups
    wire         scl = (scl_oe_n | scl_out) & scl_drv;
    wire         sda = (sda_oe_n | sda_out) & sda_drv;
    always #5 clk = ~clk;
    tbd_twi_slave i_dut (.CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
        .AVS_WRITE(wr_en), .AVS_BYTEENABLE(4'h1), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wait_req), .SCL_IN(scl), .SCL_OUT(scl_out), .SCL_OE_N(scl_oe_n),
        .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n));
    tbd_far_master i_m (.CLK(clk), .scl(scl), .sda(sda), .scl_drv(scl_drv), .sda_drv(sda_drv));
    // Byte compare; unknowns never match
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic summarize();
        miscompares += i_m.tmo;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    // Bus access held until the rising edge that sees waitrequest low; data taken there
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] r);
        int n;
        @(posedge clk);
        adr   <= {a, 2'b00};
        wdat  <= {24'h0, d};
        wr_en <= w;
        rd_en <= ~w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        r = rdat[7:0];
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            summarize();
        end
    endtask : access
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        access(1'b1, a, d, q);
    endtask : wr
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        access(1'b0, a, 8'h00, q);
        check(q, e);
    endtask : rchk
    task automatic xfer(input logic [7:0] a);
        i_m.start();
        i_m.send(a, nk);
        i_m.stop();
    endtask : xfer
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rchk(6'h18 + 6'(i), i == 5 ? 8'h40 : 8'h00);
        wr(6'h1d, 8'hff);
        rchk(6'h1d, 8'hc6);
        wr(6'h18, 8'h24);
        wr(6'h1d, 8'h00);
        rchk(6'h1d, 8'hc0);
        wr(6'h18, 8'h00);
        wr(6'h1d, 8'h00);
        wr(6'h18, 8'h24);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            wr(6'h1c, tab[2*i]);
            xfer(tab[2*i+1]);
            if (i == 0) lat0 = i_m.lat;
            check({7'h0, nk}, {7'h0, i > 1});
        end
        $display("test addressing done");
        wr(6'h18, 8'h00);
        wr(6'h1d, 8'h40);
        wr(6'h18, 8'h24);
        wr(6'h1c, 8'h55);
        i_m.start();
        i_m.send(8'h54, nk);
        check(8'(i_m.lat - lat0), 8'h02);
        i_m.send(8'ha5, nk);
        check({7'h0, nk}, 8'h00);
        fork
            i_m.send(8'h3c, nk);
            begin
                repeat (60) @(posedge clk);
                check({7'h0, scl}, 8'h00);
                rchk(6'h1e, 8'ha5);
            end
        join
        rchk(6'h1e, 8'h3c);
        i_m.stop();
        i_m.start();
        i_m.send(8'h55, nk);
        check({7'h0, nk}, 8'h00);
        fork
            i_m.recv(1'b1, q2);
            begin
                repeat (60) @(posedge clk);
                check({7'h0, scl}, 8'h00);
                wr(6'h1e, 8'h96);
            end
        join
        check(q2, 8'h96);
        i_m.stop();
        $display("test data done");
        wr(6'h18, 8'h00);
        wr(6'h1d, 8'h44);
        wr(6'h1c, 8'h5a);
        wr(6'h18, 8'h24);
        i_m.start();
        i_m.send(8'hf4, nk);
        check({7'h0, nk}, 8'h00);
        i_m.send(8'h5a, nk);
        check({7'h0, nk}, 8'h00);
        i_m.stop();
        i_m.start();
        i_m.send(8'hf4, nk);
        i_m.send(8'h5b, nk);
        check({7'h0, nk}, 8'h01);
        i_m.stop();
        xfer(8'hf2);
        check({7'h0, nk}, 8'h01);
        wr(6'h18, 8'h00);
        rchk(6'h1c, 8'h5a);
        rchk(6'h1d, 8'h44);
        $display("test ten-bit and retention done");
        summarize();
    end
endmodule : tb_top
